// ===== aio_param_irq_regs.vh
// Offsets, field positions, reset values and timing constants of the analog I/O parameter and interrupt block.
`ifndef AIO_PARAM_IRQ_REGS_VH
`define AIO_PARAM_IRQ_REGS_VH

`define AIO_CLK_NS        10
`define AIO_HALF_MS_NS    500000
`define AIO_OUT_SLOT_NS   500000
`define AIO_TIME_BASE     6
`define AIO_TIME_MAX      5'h1a

`define AIO_REG_CTRL      8'h00
`define AIO_REG_IN_CFG    8'h04
`define AIO_REG_OUT_CFG   8'h08
`define AIO_REG_SUBST     8'h0c
`define AIO_REG_RTCALL    8'h10
`define AIO_REG_STATUS    8'h14
`define AIO_REG_CLEAR     8'h18
`define AIO_REG_IRQ_EN    8'h1c
`define AIO_REG_IRQ_PTR   8'h20
`define AIO_REG_IN_STAT   8'h24
`define AIO_REG_CHAN0     8'h40

`define AIO_IN_ACT_LSB    0
`define AIO_IN_RANGE_LSB  4
`define AIO_IN_MODE_LSB   12
`define AIO_IN_TIME_LSB   14
`define AIO_IN_DIAG_BIT   19
`define AIO_IN_WBT_BIT    20
`define AIO_OUT_ACT_LSB   0
`define AIO_OUT_DIAG_BIT  4
`define AIO_OUT_POL_LSB   6

`define AIO_RANGE_V10     2'h0
`define AIO_RANGE_MA20    2'h1
`define AIO_RANGE_MA4_20  2'h2
`define AIO_MODE_NONE     2'h0
`define AIO_MODE_CYCLIC   2'h1
`define AIO_MODE_CYCEND   2'h2
`define AIO_POL_ZERO      2'h0
`define AIO_POL_LAST      2'h1
`define AIO_POL_GLOBAL    2'h2

`define AIO_CALL_FIRST    8'h37
`define AIO_CALL_LAST     8'h39
`define AIO_SUBST_MIN     16'h9400
`define AIO_SUBST_MAX     16'h6c00
`define AIO_SRC_MARKER    32'h0fffffff

`define AIO_IN_CFG_RST    32'h0000000f
`define AIO_OUT_CFG_RST   32'h0000000f
`define AIO_SUBST_RST     16'h0000

`define AIO_ST_HWIRQ      0
`define AIO_ST_IN_DIAG    1
`define AIO_ST_OUT_DIAG   2
`define AIO_ST_PARAM_ERR  3

`endif

// ===== aio_param_irq.v
// Parameter acceptance, input scan, output cycle and interrupt logic of the analog I/O unit.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "aio_param_irq_regs.vh"

module aio_param_irq #(
  parameter N_CH          = 4,
  parameter HALF_MS_CYC   = `AIO_HALF_MS_NS / `AIO_CLK_NS,
  parameter OUT_SLOT_CYC  = `AIO_OUT_SLOT_NS / `AIO_CLK_NS
) (
  // Clock and reset.
  input  wire        i_ref_clk,
  input  wire        i_resetn,
  // Register port.
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Input converter.
  output reg         o_conv_start,
  output reg  [1:0]  o_conv_chan,
  input  wire        i_conv_done,
  input  wire [15:0] i_conv_data,
  input  wire        i_conv_wirebreak,
  input  wire        i_conv_range_err,
  // Output converter.
  input  wire        i_subst_req,
  output reg         o_dac_load,
  output reg  [1:0]  o_dac_chan,
  output reg  [15:0] o_dac_data,
  // Interrupt.
  output wire        o_irq
);

  localparam S_STOP = 4'h1;
  localparam S_PICK = 4'h2;
  localparam S_CONV = 4'h4;
  localparam S_WAIT = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Staged and active parameters.

  reg  [31:0] stg_in_q;
  reg  [31:0] stg_out_q;
  reg  [15:0] stg_subst_q;
  reg  [31:0] act_in_q;
  reg  [31:0] act_out_q;
  reg  [15:0] act_subst_q;
  reg         run_q;
  reg  [3:0]  st_q;
  reg  [3:0]  en_q;
  reg  [15:0] chan_q [0:N_CH-1];
  reg  [15:0] last_q [0:N_CH-1];
  reg  [3:0]  wb_q;

  wire        wr_ctrl   = i_wr && (i_addr == `AIO_REG_CTRL);
  wire        run_rise  = wr_ctrl && i_wdata[0] && !run_q;
  wire [7:0]  call_no   = i_wdata[7:0];
  wire        rt_call   = i_wr && (i_addr == `AIO_REG_RTCALL) &&
                          (call_no >= `AIO_CALL_FIRST) && (call_no <= `AIO_CALL_LAST);
  wire [3:0]  in_act    = act_in_q[`AIO_IN_ACT_LSB +: 4];
  wire [1:0]  in_mode   = act_in_q[`AIO_IN_MODE_LSB +: 2];
  wire [4:0]  in_time   = act_in_q[`AIO_IN_TIME_LSB +: 5];
  wire        in_diag   = act_in_q[`AIO_IN_DIAG_BIT];
  wire        in_wbt    = act_in_q[`AIO_IN_WBT_BIT];
  wire [3:0]  out_act   = act_out_q[`AIO_OUT_ACT_LSB +: 4];
  wire        out_diag  = act_out_q[`AIO_OUT_DIAG_BIT];
  wire [1:0]  out_pol   = act_out_q[`AIO_OUT_POL_LSB +: 2];

  // A range code of 3, a bad mode or an interval beyond 16 ms is a parameter error.
  reg         stg_err;
  integer     k;
  always @* begin
    stg_err = (stg_in_q[`AIO_IN_MODE_LSB +: 2] == 2'h3) ||
              (stg_in_q[`AIO_IN_TIME_LSB +: 5] > `AIO_TIME_MAX) ||
              (stg_out_q[`AIO_OUT_POL_LSB +: 2] == 2'h3);
    for (k = 0; k < N_CH; k = k + 1) begin
      if (stg_in_q[`AIO_IN_RANGE_LSB + 2*k +: 2] == 2'h3) begin
        stg_err = 1'b1;
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      stg_in_q    <= `AIO_IN_CFG_RST;
      stg_out_q   <= `AIO_OUT_CFG_RST;
      stg_subst_q <= `AIO_SUBST_RST;
      act_in_q    <= `AIO_IN_CFG_RST;
      act_out_q   <= `AIO_OUT_CFG_RST;
      act_subst_q <= `AIO_SUBST_RST;
      run_q       <= 1'b0;
      en_q        <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        run_q <= i_wdata[0];
      end
      if (i_wr && (i_addr == `AIO_REG_IN_CFG)) begin
        stg_in_q <= i_wdata;
      end
      if (i_wr && (i_addr == `AIO_REG_OUT_CFG)) begin
        stg_out_q <= i_wdata;
      end
      if (i_wr && (i_addr == `AIO_REG_SUBST)) begin
        stg_subst_q <= i_wdata[15:0];
      end
      if (i_wr && (i_addr == `AIO_REG_IRQ_EN)) begin
        en_q <= i_wdata[3:0];
      end
      if (run_rise) begin
        act_in_q    <= stg_in_q;
        act_out_q   <= stg_out_q;
        act_subst_q <= stg_subst_q;
      end else if (rt_call) begin
        act_in_q[`AIO_IN_RANGE_LSB +: 8]  <= stg_in_q[`AIO_IN_RANGE_LSB +: 8];
        act_out_q[`AIO_OUT_ACT_LSB +: 4]  <= stg_out_q[`AIO_OUT_ACT_LSB +: 4];
        act_out_q[`AIO_OUT_POL_LSB +: 2]  <= stg_out_q[`AIO_OUT_POL_LSB +: 2];
        act_subst_q                       <= stg_subst_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interval timer, 3 ms plus 0.5 ms per step.

  reg  [31:0] tmr_q;
  wire [4:0]  time_cl = (in_time > `AIO_TIME_MAX) ? `AIO_TIME_MAX : in_time;
  wire [31:0] tmr_lim = ({27'h0, time_cl} + `AIO_TIME_BASE) * HALF_MS_CYC - 32'h1;
  wire        tick    = run_q && (tmr_q == tmr_lim);

  always @(posedge i_ref_clk) begin
    if (!i_resetn || !run_q || run_rise || tick) begin
      tmr_q <= 32'h0;
    end else begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input measuring cycle.

  reg  [3:0]  sm_q;
  reg  [2:0]  idx_q;
  reg         cyc_end;
  reg         wb_evt;
  reg         rng_evt;
  reg  [2:0]  nxt;
  reg         found;
  integer     j;

  always @* begin
    nxt   = 3'h4;
    found = 1'b0;
    for (j = N_CH - 1; j >= 0; j = j - 1) begin
      if (in_act[j] && (j >= idx_q)) begin
        nxt   = j[2:0];
        found = 1'b1;
      end
    end
  end

  wire [1:0] cur_rng = act_in_q[`AIO_IN_RANGE_LSB + 2*o_conv_chan +: 2];

  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      sm_q         <= S_STOP;
      idx_q        <= 3'h0;
      o_conv_start <= 1'b0;
      o_conv_chan  <= 2'h0;
      cyc_end      <= 1'b0;
      wb_evt       <= 1'b0;
      rng_evt      <= 1'b0;
      wb_q         <= 4'h0;
    end else begin
      o_conv_start <= 1'b0;
      cyc_end      <= 1'b0;
      wb_evt       <= 1'b0;
      rng_evt      <= 1'b0;
      case (sm_q)
        S_STOP: begin
          idx_q <= 3'h0;
          if (run_rise) begin
            sm_q <= S_PICK;
          end
        end
        S_PICK: begin
          if (!run_q) begin
            sm_q <= S_STOP;
          end else if (found) begin
            o_conv_chan  <= nxt[1:0];
            o_conv_start <= 1'b1;
            sm_q         <= S_CONV;
          end else begin
            cyc_end <= (in_act != 4'h0);
            idx_q   <= 3'h0;
            if (in_mode == `AIO_MODE_CYCEND) begin
              sm_q <= S_WAIT;
            end
          end
        end
        S_CONV: begin
          if (i_conv_done) begin
            chan_q[o_conv_chan] <= i_conv_data;
            idx_q               <= {1'b0, o_conv_chan} + 3'h1;
            rng_evt             <= in_diag && i_conv_range_err;
            if ((cur_rng == `AIO_RANGE_MA4_20) && (in_diag || in_wbt)) begin
              wb_q[o_conv_chan] <= i_conv_wirebreak;
              wb_evt            <= in_diag && i_conv_wirebreak;
            end else begin
              wb_q[o_conv_chan] <= 1'b0;
            end
            sm_q <= run_q ? S_PICK : S_STOP;
          end
        end
        S_WAIT: begin
          if (!run_q) begin
            sm_q <= S_STOP;
          end else if (tick) begin
            sm_q <= S_PICK;
          end
        end
        default: begin
          sm_q <= S_STOP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output cycle with fixed slots.

  reg  [31:0] slot_q;
  reg  [1:0]  och_q;
  reg         subst_q;
  wire        slot_end = (slot_q == OUT_SLOT_CYC - 1);
  reg  [15:0] oval;
  reg  [15:0] out_q [0:N_CH-1];
  wire        wr_chan  = i_wr && (i_addr[7:4] == (`AIO_REG_CHAN0 >> 4));
  integer     m;

  always @* begin
    if (!i_subst_req) begin
      oval = out_q[och_q];
    end else begin
      case (out_pol)
        `AIO_POL_LAST:   oval = last_q[och_q];
        `AIO_POL_GLOBAL: oval = act_subst_q;
        default:         oval = 16'h0000;
      endcase
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      slot_q     <= 32'h0;
      och_q      <= 2'h0;
      subst_q    <= 1'b0;
      o_dac_load <= 1'b0;
      o_dac_chan <= 2'h0;
      o_dac_data <= 16'h0000;
      for (m = 0; m < N_CH; m = m + 1) begin
        out_q[m]  <= 16'h0000;
        last_q[m] <= 16'h0000;
      end
    end else begin
      subst_q    <= i_subst_req;
      if (wr_chan) begin
        out_q[i_addr[3:2]] <= i_wdata[15:0];
      end
      o_dac_load <= 1'b0;
      if (slot_end) begin
        slot_q <= 32'h0;
        och_q  <= och_q + 2'h1;
        if (out_act[och_q]) begin
          o_dac_load <= 1'b1;
          o_dac_chan <= och_q;
          o_dac_data <= oval;
          if (!i_subst_req) begin
            last_q[och_q] <= oval;
          end
        end
      end else begin
        slot_q <= slot_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear.

  reg  [3:0] set_v;
  always @* begin
    set_v = 4'h0;
    if (in_mode == `AIO_MODE_CYCLIC) begin
      set_v[`AIO_ST_HWIRQ] = tick;
    end else if (in_mode == `AIO_MODE_CYCEND) begin
      set_v[`AIO_ST_HWIRQ] = cyc_end;
    end
    set_v[`AIO_ST_IN_DIAG] = wb_evt || rng_evt;
    set_v[`AIO_ST_OUT_DIAG]  = out_diag && i_subst_req && !subst_q;
    set_v[`AIO_ST_PARAM_ERR] = run_rise && stg_err && (stg_out_q[`AIO_OUT_DIAG_BIT] || stg_in_q[`AIO_IN_DIAG_BIT]);
  end

  // A new event wins over a clear in the same cycle so that none is lost.
  wire [3:0] clr_v = (i_wr && (i_addr == `AIO_REG_CLEAR)) ? i_wdata[3:0] : 4'h0;
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_q <= 4'h0;
    end else begin
      st_q <= (st_q & ~clr_v) | set_v;
    end
  end

  assign o_irq = |(st_q & en_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Register read, one cycle after the strobe.

  wire [1:0]  rch = i_addr[3:2];
  wire        in_chan = (i_addr[7:4] == `AIO_REG_CHAN0 >> 4);
  reg  [31:0] rd_v;
  always @* begin
    rd_v = 32'h0;
    case (i_addr)
      `AIO_REG_CTRL:    rd_v = {24'h0, sm_q, 3'h0, run_q};
      `AIO_REG_IN_CFG:  rd_v = act_in_q;
      `AIO_REG_OUT_CFG: rd_v = act_out_q;
      `AIO_REG_SUBST:   rd_v = {16'h0, act_subst_q};
      `AIO_REG_STATUS:  rd_v = {28'h0, st_q};
      `AIO_REG_IRQ_EN:  rd_v = {28'h0, en_q};
      `AIO_REG_IRQ_PTR: rd_v = `AIO_SRC_MARKER;
      `AIO_REG_IN_STAT: rd_v = {24'h0, wb_q, 1'b0, idx_q};
      default: begin
        if (in_chan) begin
          rd_v = {16'h0, chan_q[rch]};
        end
      end
    endcase
  end

  // Channel words are written by software as output values and read back as input values.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rd_v : 32'h0;
    end
  end

endmodule // aio_param_irq

// ===== aio_param_irq_assertions.sv
// Concurrent checks on the ports of the analog I/O parameter and interrupt block.
`timescale 1ns/1ps
module aio_param_irq_assertions #(
  parameter OUT_SLOT_CYC = 4
) (
  // Clock, reset and register port.
  input wire        i_ref_clk,
  input wire        i_resetn,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  // Converters and interrupt.
  input wire        o_conv_start,
  input wire        i_conv_done,
  input wire        o_dac_load,
  input wire [15:0] o_dac_data,
  input wire        o_irq
);
  logic        pend_q;
  logic        seen_q;
  logic [31:0] en_q;
  int          gap_q;

  // Shadow state so the checks can tie outputs to earlier requests.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pend_q <= 1'b0;
      seen_q <= 1'b0;
      en_q   <= 32'h0;
      gap_q  <= 0;
    end else begin
      pend_q <= o_conv_start | (pend_q & ~i_conv_done);
      seen_q <= seen_q | o_dac_load;
      en_q   <= (i_wr && i_addr == 8'h1c) ? i_wdata : en_q;
      gap_q  <= o_dac_load ? 0 : gap_q + 1;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_ptr_rd;
    i_rd && i_addr == 8'h20;
  endsequence
  sequence s_en_off;
    i_wr && i_addr == 8'h1c && i_wdata == 32'h0;
  endsequence
  sequence s_conv_end;
    i_conv_done && pend_q;
  endsequence

  a_ptr_marker:
    assert property (s_ptr_rd |=> o_rdata == 32'h0fffffff) else $error("pointer read lacks marker");
  a_rd_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside its cycle");
  a_unmapped_zero:
    assert property (i_rd && i_addr == 8'h30 |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  a_one_conv:
    assert property (o_conv_start |-> !pend_q) else $error("second conversion started early");
  a_pick_gap:
    assert property (s_conv_end |=> !o_conv_start) else $error("start right after done");
  a_irq_cause:
    assert property (o_irq |-> en_q != 32'h0) else $error("interrupt with nothing enabled");
  a_irq_off:
    assert property (s_en_off |=> !o_irq) else $error("interrupt after disable");
  // Deactivated output channels keep their slot, so loads sit on the slot grid.
  a_slot_grid:
    assert property (o_dac_load && seen_q |-> (gap_q + 1) % OUT_SLOT_CYC == 0) else $error("load off slot grid");
  a_dac_hold:
    assert property (!o_dac_load |-> $stable(o_dac_data)) else $error("output changed without load");
endmodule // aio_param_irq_assertions

bind aio_param_irq aio_param_irq_assertions #(.OUT_SLOT_CYC(OUT_SLOT_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_conv_start(o_conv_start),
  .i_conv_done(i_conv_done), .o_dac_load(o_dac_load), .o_dac_data(o_dac_data), .o_irq(o_irq)
);

// ===== aio_conv_model.sv
// Behavioural input converter that answers every conversion start.
`timescale 1ns/1ps
module aio_conv_model (
  // Control.
  input  wire logic        i_clk,
  input  wire logic        i_start,
  input  wire logic [1:0]  i_chan,
  input  wire logic        i_slow,
  input  wire logic        i_wb_on,
  // Result.
  output logic             o_done,
  output logic [15:0]      o_data,
  output logic             o_wb,
  output logic             o_rerr
);
  logic        busy_q = 1'b0;
  logic [3:0]  cnt_q = 4'h0;
  logic [15:0] val_q = 16'h0;
  initial o_done = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // one answer per start.
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    val_q  <= val_q + 16'h0123;
    if (i_start) begin
      busy_q <= 1'b1;
      cnt_q  <= i_slow ? 4'h9 : 4'h2;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end
  // flags only with result.
  // Data and wire-break lines change every cycle outside the result, the range-error line every second cycle, so stale values are never trusted.
  assign o_data = o_done ? {i_chan, val_q[13:0]} : ~val_q;
  assign o_wb   = o_done ? i_wb_on : val_q[0];
  assign o_rerr = o_done ? 1'b0 : val_q[1];
endmodule // aio_conv_model

// ===== aio_param_irq_tb_top.sv
// Self-checking testbench of the analog I/O parameter and interrupt block.
`timescale 1ns/1ps
module aio_param_irq_tb_top;
  localparam int HC = 4;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_subst_req = 1'b0;
  logic        slow = 1'b0;
  logic        wb_on = 1'b0;
  logic        i_conv_done, i_conv_wirebreak, i_conv_range_err, o_conv_start, o_dac_load, o_irq;
  logic [15:0] i_conv_data, o_dac_data;
  logic [1:0]  o_conv_chan;
  logic [31:0] o_rdata, rd_v, cfg, act_cfg;
  logic [3:0]  act = 4'hf;
  integer      seed = 32'hbb87a6c9;
  int          error_cnt = 0, total_checks = 0, bad = 0, n_st = 0;
  time         t1;

  always #5 i_ref_clk = ~i_ref_clk;

  aio_param_irq #(.HALF_MS_CYC(HC), .OUT_SLOT_CYC(HC)) dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
    .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .i_conv_wirebreak(i_conv_wirebreak),
    .i_conv_range_err(i_conv_range_err), .i_subst_req(i_subst_req), .o_dac_load(o_dac_load),
    .o_dac_chan(), .o_dac_data(o_dac_data), .o_irq(o_irq));

  aio_conv_model u_conv (.i_clk(i_ref_clk), .i_start(o_conv_start), .i_chan(o_conv_chan), .i_slow(slow),
    .i_wb_on(wb_on), .o_done(i_conv_done), .o_data(i_conv_data), .o_wb(i_conv_wirebreak),
    .o_rerr(i_conv_range_err));

  always @(posedge i_ref_clk) begin
    n_st <= n_st + o_conv_start;
    bad  <= bad + (o_conv_start && !act[o_conv_chan]);
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] ival(input [4:0] t);
    ival = HC * (6 + ((t > 5'd26) ? 5'd26 : t));
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rchk(input [7:0] a, input [31:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    @(negedge i_ref_clk);
    rd_v = o_rdata;
    chk(rd_v, exp);
  endtask
  // The pause after stop lets a slow conversion finish before the new scan starts.
  task automatic run_cfg(input [31:0] ic, input [31:0] oc, input [3:0] a);
    wr(8'h04, ic);
    wr(8'h08, oc);
    wr(8'h00, 32'h0);
    repeat (12) @(posedge i_ref_clk);
    act = a;
    wr(8'h00, 32'h1);
  endtask
  task automatic wait_sig(input bit irq);
    int k;
    k = 0;
    do begin
      @(negedge i_ref_clk);
      k++;
    end while ((irq ? o_irq : o_dac_load) !== 1'b1 && k < 300);
    if (k >= 300) chk(32'h0, 32'h1);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    act_cfg = 32'hf;
    rchk(8'h08, 32'hf);
    rchk(8'h20, 32'h0fffffff);
    rchk(8'h30, 32'h0);
    $display("test reset done");
    wr(8'h1c, 32'h1);
    for (int i = 0; i < 3; i++) begin
      seed = $random(seed);
      slow <= (i == 2) ? 1'b0 : seed[0];
      cfg = {13'h0, (i == 1) ? 5'h1f : 5'h00, (i == 2) ? 2'h2 : 2'h1, 8'h00, 4'h5};
      wr(8'h04, cfg);
      rchk(8'h04, act_cfg);
      run_cfg(cfg, 32'hf, 4'h5);
      act_cfg = cfg;
      rchk(8'h04, cfg);
      wr(8'h18, 32'hf);
      wait_sig(1'b1);
      t1 = $time;
      wr(8'h18, 32'hf);
      wait_sig(1'b1);
      chk(32'(($time - t1) / 10), ival(cfg[18:14]));
    end
    chk(bad, 0);
    $display("test interrupt modes done");
    for (int n = 8'h37; n <= 8'h3a; n++) begin
      seed = $random(seed);
      wr(8'h04, {act_cfg[31:19], ~act_cfg[18:14], 2'h1, seed[7:0], 4'ha});
      wr(8'h10, n);
      if (n < 8'h3a) act_cfg[11:4] = seed[7:0];
      rchk(8'h04, act_cfg);
    end
    $display("test runtime call done");
    run_cfg(32'hf, 32'hf, 4'hf);
    wr(8'h18, 32'hf);
    repeat (200) @(posedge i_ref_clk);
    rchk(8'h14, 32'h0);
    chk(n_st > 0, 1);
    wb_on <= 1'b1;
    run_cfg(32'h001800e5, 32'hf, 4'h5);
    repeat (100) @(posedge i_ref_clk);
    wr(8'h00, 32'h0);
    repeat (12) @(posedge i_ref_clk);
    rchk(8'h24, 32'h10);
    rchk(8'h14, 32'ha);
    wb_on <= 1'b0;
    $display("test wire break done");
    seed = $random(seed);
    wr(8'h0c, {16'h0, seed[15:0]});
    run_cfg(32'hf, 32'h9f, 4'hf);
    wr(8'h18, 32'hf);
    i_subst_req <= 1'b1;
    @(posedge i_ref_clk);
    wait_sig(1'b0);
    chk(o_dac_data, seed[15:0]);
    rchk(8'h14, 32'h4);
    wr(8'h08, 32'h1f);
    wr(8'h10, 32'h38);
    wait_sig(1'b0);
    wait_sig(1'b0);
    chk(o_dac_data, 32'h0);
    i_subst_req <= 1'b0;
    seed = $random(seed);
    for (int c = 0; c < 4; c++) wr(8'(8'h40 + 4 * c), seed);
    repeat (20) @(posedge i_ref_clk);
    wait_sig(1'b0);
    chk(o_dac_data, seed[15:0]);
    wr(8'h08, 32'h5f);
    wr(8'h10, 32'h39);
    i_subst_req <= 1'b1;
    @(posedge i_ref_clk);
    wait_sig(1'b0);
    chk(o_dac_data, seed[15:0]);
    wr(8'h1c, 32'h4);
    @(negedge i_ref_clk);
    chk(o_irq, 1'b1);
    wr(8'h1c, 32'h0);
    @(negedge i_ref_clk);
    chk(o_irq, 1'b0);
    repeat (2) @(posedge i_ref_clk);
    i_subst_req <= 1'b0;
    $display("test substitution done");
    finish_test;
  end
endmodule // aio_param_irq_tb_top
